// ### include/clk_cfg_params.svh
// Offsets, field positions, reset value and timing counts of the clock config
`ifndef CLK_CFG_PARAMS_SVH
`define CLK_CFG_PARAMS_SVH
`define CFG_W 8
`define CFG_RESTART_BIT 7
`define CFG_PLL_EN_BIT 6
`define CFG_OSC_EN_BIT 5
`define CFG_MODE_HI 4
`define CFG_MODE_LO 3
`define CFG_SEL_HI 2
`define CFG_SEL_LO 0
`define CFG_RESET_VAL 8'h00
`define CLK_PERIOD_NS 4
`define SWITCH_DELAY_NS 75000
`define SWITCH_CYCLES ((`SWITCH_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PLL_MULT 5'h10
`define PLL_MAX_SHIFT 3'h4
`endif

// ### include/clk_cfg_pkg.sv
// Types shared by the clock configuration block
package clk_cfg_pkg;
  typedef enum logic [2:0] {
    SRC_RC_FAST = 3'h0,
    SRC_RC_SLOW = 3'h1,
    SRC_OSC = 3'h2,
    SRC_PLL1X = 3'h3,
    SRC_PLL2X = 3'h4,
    SRC_PLL4X = 3'h5,
    SRC_PLL8X = 3'h6,
    SRC_PLL16X = 3'h7
  } source_t;

  typedef enum logic [1:0] {
    MODE_EXT_CLOCK = 2'h0,
    MODE_XTAL_LOW = 2'h1,
    MODE_XTAL_MID = 2'h2,
    MODE_XTAL_HIGH = 2'h3
  } drive_mode_t;

  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_SWITCH = 2'b10
  } switch_state_t;
endpackage

// ### core/clock_source_select.sv
// Decode of the source select field into PLL tap and enable checks
`include "clk_cfg_params.svh"
module clock_source_select (
  input wire clk_cfg_pkg::source_t sel,
  input wire logic osc_en,
  input wire logic pll_en,
  output logic pll_feed,
  output logic [2:0] pll_shift,
  output logic uses_pll,
  output logic sel_ready
);
  import clk_cfg_pkg::*;

  // Oscillator signal reaches the PLL only with both enables set
  assign pll_feed = osc_en & pll_en;

  // PLL runs at 16x input; taps 1x..16x are right shifts of 4..0
  always_comb begin
    uses_pll = 1'b0;
    pll_shift = `PLL_MAX_SHIFT;
    sel_ready = 1'b1;
    case (sel)
      SRC_RC_FAST, SRC_RC_SLOW: begin
        sel_ready = 1'b1;
      end
      SRC_OSC: begin
        sel_ready = osc_en;
      end
      default: begin
        uses_pll = 1'b1;
        pll_shift = 3'(`PLL_MAX_SHIFT - 3'(sel - SRC_PLL1X));
        sel_ready = osc_en & pll_en;
      end
    endcase
  end
endmodule // clock_source_select

// ### core/system_clock_config.sv
// Clock configuration register, switch-over hold and oscillator pin logic
`include "clk_cfg_params.svh"
module system_clock_config #(
  parameter int SWITCH_CYCLES = `SWITCH_CYCLES
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic cfg_wr_stb,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  input wire logic osc_input_pin,
  output logic osc_output_pin_o,
  output logic osc_output_pin_oe,
  output logic osc_input_level,
  output logic pll_enable_o,
  output logic pll_feed_o,
  output logic [4:0] pll_mult_o,
  output logic osc_enable_o,
  output clk_cfg_pkg::drive_mode_t drive_mode_o,
  output clk_cfg_pkg::source_t master_sel_o,
  output logic [2:0] pll_shift_o,
  output logic source_ready_o,
  output logic hold_exec_o,
  output logic chip_restart_o
);
  import clk_cfg_pkg::*;

  logic [7:0] cfg_q;
  switch_state_t state_q;
  logic [31:0] cnt_q;
  logic restart_q;
  logic sync1_q, sync2_q, sync3_q;
  logic level_q;
  logic wr_take;
  logic wr_restart;
  source_t sel_field;
  logic dec_feed, dec_uses_pll, dec_ready;
  logic [2:0] dec_shift;

  // Writes are taken only while the chip is not stalled
  assign wr_take = cfg_wr_stb & (state_q == ST_RUN);
  assign wr_restart = wr_take & cfg_wdata[`CFG_RESTART_BIT];
  assign sel_field = source_t'(cfg_q[`CFG_SEL_HI:`CFG_SEL_LO]);

  // Register store; restart bit is never held, so it reads zero
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cfg_q <= `CFG_RESET_VAL;
    end else if (wr_restart) begin
      cfg_q <= `CFG_RESET_VAL;
    end else if (wr_take) begin
      cfg_q <= {1'b0, cfg_wdata[6:0]};
    end
  end

  // Software_restart_cmd request, one cycle wide, acts like a hardware reset
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      restart_q <= 1'b0;
    end else begin
      restart_q <= wr_restart;
    end
  end

  // Switch-over hold: runt pulses must not reach the logic, so the
  // whole chip waits for the full delay before the new source is used
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_RUN;
      cnt_q <= 32'h0000_0000;
    end else begin
      case (state_q)
        ST_RUN: begin
          if (wr_take && !wr_restart) begin
            state_q <= ST_SWITCH;
            cnt_q <= 32'(SWITCH_CYCLES - 1);
          end
        end
        ST_SWITCH: begin
          if (cnt_q == 32'h0000_0000) begin
            state_q <= ST_RUN;
          end else begin
            cnt_q <= cnt_q - 32'h0000_0001;
          end
        end
        default: begin
          state_q <= ST_RUN;
        end
      endcase
    end
  end

  clock_source_select u_sel (
    .sel(sel_field),
    .osc_en(cfg_q[`CFG_OSC_EN_BIT]),
    .pll_en(cfg_q[`CFG_PLL_EN_BIT]),
    .pll_feed(dec_feed),
    .pll_shift(dec_shift),
    .uses_pll(dec_uses_pll),
    .sel_ready(dec_ready)
  );

  // Enables act at once so the circuits start settling during the hold;
  // both may be set in a single write and share that settling time
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pll_enable_o <= 1'b0;
      osc_enable_o <= 1'b0;
      pll_feed_o <= 1'b0;
      drive_mode_o <= MODE_EXT_CLOCK;
      pll_mult_o <= 5'h00;
    end else begin
      pll_enable_o <= cfg_q[`CFG_PLL_EN_BIT];
      osc_enable_o <= cfg_q[`CFG_OSC_EN_BIT];
      pll_feed_o <= dec_feed;
      drive_mode_o <= drive_mode_t'(cfg_q[`CFG_MODE_HI:`CFG_MODE_LO]);
      pll_mult_o <= cfg_q[`CFG_PLL_EN_BIT] ? `PLL_MULT : 5'h00;
    end
  end

  // Master source changes only when the hold has run out, or on the cycle after a restart write, with no hold
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      master_sel_o <= SRC_RC_FAST;
      pll_shift_o <= `PLL_MAX_SHIFT;
      source_ready_o <= 1'b1;
    end else if (state_q == ST_RUN) begin
      master_sel_o <= sel_field;
      pll_shift_o <= dec_uses_pll ? dec_shift : `PLL_MAX_SHIFT;
      source_ready_o <= dec_ready;
    end
  end

  // Status outputs
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cfg_rdata <= `CFG_RESET_VAL;
      hold_exec_o <= 1'b0;
      chip_restart_o <= 1'b0;
    end else begin
      cfg_rdata <= cfg_q;
      hold_exec_o <= (state_q == ST_SWITCH);
      chip_restart_o <= restart_q;
    end
  end

  // Pin input crosses in through three flops; a change counts once the
  // last two agree, which also rejects a single-cycle glitch
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
      level_q <= 1'b0;
    end else begin
      sync1_q <= osc_input_pin;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      if (sync2_q == sync3_q) begin
        level_q <= sync3_q;
      end
    end
  end

  // Crystal modes run the pins as an inverting feedback loop; the
  // external clock mode leaves the output pin undriven
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      osc_output_pin_o <= 1'b0;
      osc_output_pin_oe <= 1'b0;
      osc_input_level <= 1'b0;
    end else begin
      osc_output_pin_oe <= cfg_q[`CFG_OSC_EN_BIT] &&
        (cfg_q[`CFG_MODE_HI:`CFG_MODE_LO] != 2'h0);
      osc_output_pin_o <= cfg_q[`CFG_OSC_EN_BIT] & ~level_q;
      osc_input_level <= cfg_q[`CFG_OSC_EN_BIT] & level_q;
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  sequence s_write;
    wr_take && !wr_restart;
  endsequence

  sequence s_hold_run;
    hold_exec_o [*8];
  endsequence

  property p_hold_starts;
    s_write |=> ##1 hold_exec_o;
  endproperty
  a_hold_starts: assert property (p_hold_starts)
    else $error("hold did not start after a write");

  property p_hold_span;
    s_write |=> ##1 s_hold_run;
  endproperty
  a_hold_span: assert property (p_hold_span)
    else $error("hold shorter than eight cycles");

  property p_hold_count;
    (state_q == ST_SWITCH && cnt_q == 32'h0000_0000) |=> state_q == ST_RUN;
  endproperty
  a_hold_count: assert property (p_hold_count)
    else $error("hold did not end at zero count");

  // The source may move on the edge that ends the hold, so the check is
  // made in the same cycle that shows the hold, not the one after
  property p_sel_frozen;
    hold_exec_o |-> $stable(master_sel_o);
  endproperty
  a_sel_frozen: assert property (p_sel_frozen)
    else $error("source changed during hold");

  property p_restart;
    wr_restart |-> ##2 chip_restart_o ##1 !chip_restart_o;
  endproperty
  a_restart: assert property (p_restart)
    else $error("restart pulse wrong");

  property p_restart_clears;
    wr_restart |=> cfg_q == `CFG_RESET_VAL && state_q == ST_RUN;
  endproperty
  a_restart_clears: assert property (p_restart_clears)
    else $error("restart did not clear the register");

  property p_store;
    s_write |=> ##1 !cfg_rdata[7] &&
      cfg_rdata[6:0] == $past(cfg_wdata[6:0], 2);
  endproperty
  a_store: assert property (p_store)
    else $error("read back differs from written value");

  property p_feed;
    pll_feed_o |-> osc_enable_o && pll_enable_o;
  endproperty
  a_feed: assert property (p_feed)
    else $error("PLL fed with oscillator off");

  property p_pll_enable;
    s_write |=> ##1 pll_enable_o == $past(cfg_wdata[`CFG_PLL_EN_BIT], 2);
  endproperty
  a_pll_enable: assert property (p_pll_enable)
    else $error("PLL enable not applied");

  property p_osc_off;
    !osc_enable_o |-> !osc_output_pin_oe;
  endproperty
  a_osc_off: assert property (p_osc_off)
    else $error("oscillator pin driven while disabled");

  property p_mode;
    s_write |=> ##1 drive_mode_o == $past(cfg_wdata[4:3], 2);
  endproperty
  a_mode: assert property (p_mode)
    else $error("drive mode not applied");
endmodule // system_clock_config

// ### tb/osc_source_model.sv
// Behavioural external clock on the oscillator input pin
module osc_source_model #(
  parameter int HALF_NS = 100
) (
  input wire logic drive_en,
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // 5 MHz keeps the PLL inside its band; it stops while the amplifier is off
  initial begin
    pin = 1'b0;
    forever begin
      #(HALF_NS);
      if (drive_en) pin = ~pin;
    end
  end
endmodule // osc_source_model

// ### tb/testbench.sv
// Self-checking bench for the clock configuration block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import clk_cfg_pkg::*;
  localparam int N = 12;
  logic clk_sys, arst_n, cfg_wr_stb, pin, oe, lvl, lvl_q, pll_en, feed;
  logic osc_en, ready, hold, rst_req, pin_o;
  logic [7:0] cfg_wdata, cfg_rdata;
  logic [7:0] cur, nxt;
  logic [4:0] mult;
  logic [2:0] shift;
  logic [31:0] rnd;
  drive_mode_t mode;
  source_t sel;
  int failures, n_compared, cycles, toggles;

  system_clock_config #(.SWITCH_CYCLES(N)) i_system_clock_config (
    .clk_sys(clk_sys), .arst_n(arst_n), .cfg_wr_stb(cfg_wr_stb),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .osc_input_pin(pin),
    .osc_output_pin_o(pin_o), .osc_output_pin_oe(oe),
    .osc_input_level(lvl),
    .pll_enable_o(pll_en), .pll_feed_o(feed), .pll_mult_o(mult),
    .osc_enable_o(osc_en), .drive_mode_o(mode), .master_sel_o(sel),
    .pll_shift_o(shift), .source_ready_o(ready), .hold_exec_o(hold),
    .chip_restart_o(rst_req));

  osc_source_model i_osc_source_model (.drive_en(osc_en), .pin(pin));

  // Tap shift: 4 for 1x down to 0 for 16x, 4 off the PLL
  function automatic logic [2:0] exp_shift(logic [2:0] s);
    return (s >= 3'h3) ? 3'h7 - s : 3'h4;
  endfunction
  function automatic logic exp_ready(logic [7:0] v);
    return (v[2:0] < 3'h2) ? 1'b1 : (v[2:0] == 3'h2) ? v[5] : v[5] & v[6];
  endfunction
  function automatic logic [31:0] lfsr(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
    n_compared++;
    if (exp !== got) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // One write, then the whole switch-over walk; intrude tries a dropped write
  task automatic wr(logic [7:0] v, bit intrude);
    logic [2:0] old;
    old = sel;
    @(negedge clk_sys);
    cfg_wr_stb = 1'b1;
    cfg_wdata = v;
    @(negedge clk_sys);
    cfg_wr_stb = 1'b0;
    // Shadow of the register after the write, as software keeps it; zero after a restart write
    cur = v[7] ? 8'h00 : v;
    @(negedge clk_sys);
    // The restart pulse stands only in the second cycle after the take
    if (v[7]) begin
      chk("restart", 1, rst_req);
      chk("rdata", 8'h00, cfg_rdata);
      chk("no_hold", 0, hold);
      chk("enables", 0, {pll_en, osc_en});
      @(negedge clk_sys);
      chk("restart_end", 0, rst_req);
      return;
    end
    @(negedge clk_sys);
    chk("rdata", v, cfg_rdata);
    chk("hold", 1, hold);
    chk("pll_en", v[6], pll_en);
    chk("mult", v[6] ? 8'h10 : 8'h00, mult);
    chk("feed", v[6] & v[5], feed);
    chk("osc_en", v[5], osc_en);
    chk("mode", v[4:3], mode);
    chk("pin_oe", v[5] & (v[4:3] != 2'h0), oe);
    chk("sel_frozen", old, sel);
    // Hold shows for N cycles; the last check lands in its final cycle
    if (intrude) begin
      @(negedge clk_sys);
      cfg_wr_stb = 1'b1;
      cfg_wdata = ~v & 8'h7F;
      @(negedge clk_sys);
      cfg_wr_stb = 1'b0;
      repeat (N - 4) @(negedge clk_sys);
    end else begin
      repeat (N - 2) @(negedge clk_sys);
    end
    chk("hold_span", 1, hold);
    @(negedge clk_sys);
    chk("hold_end", 0, hold);
    chk("sel", v[2:0], sel);
    chk("shift", exp_shift(v[2:0]), shift);
    chk("ready", exp_ready(v), ready);
    chk("rdata_kept", v, cfg_rdata);
    if (!v[5]) chk("level_off", 0, lvl);
    chk("pin_out", {7'h00, v[5] & ~lvl}, pin_o);
    @(negedge clk_sys);
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // Ceiling far above the ~800 cycles the sequence needs
  always @(posedge clk_sys) begin
    cycles++;
    lvl_q <= lvl;
    if (lvl !== lvl_q) toggles++;
    if (cycles == 20000) begin
      failures++;
      give_verdict();
    end
  end

  initial begin
    arst_n = 1'b0;
    cfg_wr_stb = 1'b0;
    cfg_wdata = 8'h00;
    rnd = 32'hF63C43BD;
    cur = 8'h00;
    nxt = 8'h00;
    repeat (10) @(negedge clk_sys);
    chk("rst_rdata", 8'h00, cfg_rdata);
    chk("rst_shift", 3'h4, shift);
    chk("rst_ready", 1, ready);
    chk("rst_hold", 0, hold);
    arst_n = 1'b1;
    // Both circuits enabled in one write; the hold stands in for the
    // settling time, scaled down so the run stays short
    wr(8'h60, 1'b0);
    wr(8'h67, 1'b1);
    // Every source in every mode once; restart bit kept clear
    for (int i = 0; i < 32; i++) begin
      rnd = lfsr(rnd);
      nxt = {1'b0, rnd[6:5], 5'(i)};
      // PLL taps only after a write that has already set both enables
      if (nxt[2:0] >= 3'h3) begin
        nxt[6:5] = 2'b11;
        if (cur[6:5] != 2'b11) begin
          wr({1'b0, 2'b11, cur[4:0]}, 1'b0);
        end
      end
      wr(nxt, rnd[8]);
    end
    wr(8'h20, 1'b0);
    toggles = 0;
    repeat (150) @(negedge clk_sys);
    chk("pin_follow", 1, toggles > 1);
    chk("pin_out", {7'h00, ~lvl}, pin_o);
    wr(8'h80, 1'b0);
    give_verdict();
  end
endmodule // testbench
